// >>> include/shift_ptr_pkg.sv
// Constants, operation codes and field layout for the shift, pointer and mask-test datapath.
// Assumes the core decoder supplies operands already fetched and takes results one cycle later.
// Notes on behaviour
// - Single-bit arithmetic left shift moves the whole destination register left by one.
// - Single-bit arithmetic right shift moves the whole destination right, keeping sign.
// - Barrel left shift moves first source left by second source's low four bits.
// - Barrel arithmetic right shift moves first source right, sign kept, by four low bits.
// - Arithmetic shift-accumulate shifts a source word and adds it into the accumulator.
// - Single-bit logical shifts move a 16-bit word one place, zero entering.
// - Barrel logical right shift moves first source right by four low bits, zero fill.
// - Barrel logical right shift into an accumulator clears the extension bits.
// - Logical shift-accumulate shifts a source word logically and adds it into the accumulator.
// - Left rotate through carry: old carry enters bit zero, old top bit becomes carry.
// - Right rotate through carry: old carry enters top bit, bit zero becomes carry.
// - Pointer post-increment and post-decrement add or subtract one.
// - Indexed pointer update adds the offset register into the pointer.
// - Short-offset update adds a zero-extended six-bit immediate to pointer two.
// - Stack adjustment subtracts a zero-extended six-bit immediate from the stack pointer.
// - Long-offset form adds a sign-extended 16-bit immediate to the pointer.
// - Test-then-decrement tests the pointer value, then decrements it by one.
// - All-ones mask test sets carry when every masked bit is one, else clears it.
// - All-zeros mask test sets carry when every masked bit is zero, else clears it.
// - Short direct memory form carries a six-bit absolute data address.
// - Short peripheral form carries a six-bit absolute address in the I/O region.
// - Constant AND, XOR and OR combine an operand with a 16-bit immediate.
// - Word operands for arithmetic accumulator sums are sign-extended, logical ones zero-extended, both padded with sixteen zeros.
package shift_ptr_pkg;

    // ----------------------------------------
    // Widths and field positions
    // ----------------------------------------
    localparam int WORD_W = 16;
    localparam int ACC_W = 36;
    localparam int EXT_W = 4;
    localparam int SHAMT_W = 4;
    localparam int SHORT_ADDR_W = 6;
    localparam int WORD_LO = 16;
    localparam int EXT_LO = 32;
    localparam logic [WORD_W-1:0] IO_REGION_BASE = 16'hFFC0;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [ACC_W-1:0] ACC_ZERO = 36'h000000000;
    localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;

    // ----------------------------------------
    // Operation codes
    // ----------------------------------------
    typedef enum logic [4:0] {
        OP_NONE,
        OP_ARITH_SHIFT_LEFT_ONE,
        OP_ARITH_SHIFT_RIGHT_ONE,
        OP_ARITH_BARREL_LEFT,
        OP_ARITH_BARREL_RIGHT,
        OP_ARITH_SHIFT_ACCUMULATE,
        OP_LOGICAL_LEFT_ONE,
        OP_LOGICAL_RIGHT_ONE,
        OP_LOGICAL_BARREL_RIGHT,
        OP_LOGICAL_SHIFT_ACCUMULATE,
        OP_ROTATE_LEFT_VIA_CARRY,
        OP_ROTATE_RIGHT_VIA_CARRY,
        OP_PTR_INCREMENT,
        OP_PTR_DECREMENT,
        OP_PTR_ADD_OFFSET,
        OP_PTR_TWO_ADD_SHORT,
        OP_STACK_SUB_SHORT,
        OP_PTR_ADD_LONG,
        OP_TEST_THEN_DECREMENT,
        OP_MASK_ALL_ONES_TEST,
        OP_MASK_ALL_ZEROS_TEST,
        OP_SHORT_DIRECT_ADDRESS,
        OP_SHORT_IO_ADDRESS,
        OP_AND_WITH_CONSTANT,
        OP_XOR_WITH_CONSTANT,
        OP_OR_WITH_CONSTANT,
        OP_INVERT_ALIAS
    } op_t;

endpackage

// >>> rtl/shift_pointer_bittest_datapath.sv
// Shift, rotate, pointer-update and mask-test datapath of the processor core.
// Assumes the decoder presents one operation per valid cycle with operands already read.
`timescale 1ns/100ps
module shift_pointer_bittest_datapath
    import shift_ptr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire op_t op_code_i,
    input wire logic dest_is_acc_i,
    input wire logic [ACC_W-1:0] dest_i,
    input wire logic [WORD_W-1:0] src1_i,
    input wire logic [WORD_W-1:0] src2_i,
    input wire logic [ACC_W-1:0] acc_i,
    input wire logic carry_i,
    input wire logic [WORD_W-1:0] pointer_reg_i,
    input wire logic [WORD_W-1:0] offset_i,
    input wire logic [WORD_W-1:0] imm_i,
    input wire logic [SHORT_ADDR_W-1:0] short_addr_i,
    output logic [ACC_W-1:0] result_o,
    output logic result_we_o,
    output logic carry_o,
    output logic carry_we_o,
    output logic [WORD_W-1:0] pointer_reg_o,
    output logic pointer_we_o,
    output logic ptr_zero_o,
    output logic ptr_negative_o,
    output logic ptr_flags_we_o,
    output logic [WORD_W-1:0] mem_addr_o,
    output logic mem_addr_valid_o,
    output logic done_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // The 16-bit word of a destination: the middle word of an accumulator, else the register.
    function automatic logic [WORD_W-1:0] word_of(input logic [ACC_W-1:0] v, input logic is_acc);
        word_of = is_acc ? v[EXT_LO-1:WORD_LO] : v[WORD_W-1:0];
    endfunction

    // Writing a word back keeps the other accumulator fields untouched.
    function automatic logic [ACC_W-1:0] put_word(input logic [ACC_W-1:0] v,
                                                  input logic [WORD_W-1:0] w,
                                                  input logic is_acc);
        put_word = is_acc ? {v[ACC_W-1:EXT_LO], w, v[WORD_LO-1:0]} : {20'h00000, w};
    endfunction

    // Sign extension into the top field with sixteen zero low bits.
    function automatic logic [ACC_W-1:0] acc_form(input logic [WORD_W-1:0] w);
        acc_form = {{EXT_W{w[WORD_W-1]}}, w, WORD_ZERO};
    endfunction

    // Sixteen-bit results land in an accumulator in accumulator form, else as a plain word.
    function automatic logic [ACC_W-1:0] place_signed(input logic [WORD_W-1:0] w,
                                                      input logic is_acc);
        place_signed = is_acc ? acc_form(w) : {20'h00000, w};
    endfunction

    // ----------------------------------------
    // Operation evaluation
    // ----------------------------------------
    logic [ACC_W-1:0] res_next;
    logic res_we_next;
    logic carry_next;
    logic carry_we_next;
    logic [WORD_W-1:0] ptr_next;
    logic ptr_we_next;
    logic zero_next;
    logic neg_next;
    logic flags_we_next;
    logic [WORD_W-1:0] addr_next;
    logic addr_we_next;

    logic [WORD_W-1:0] dword;
    logic [SHAMT_W-1:0] shamt;
    logic [WORD_W-1:0] barrel_left;
    logic [WORD_W-1:0] barrel_arith_right;
    logic [WORD_W-1:0] barrel_logic_right;
    logic [WORD_W-1:0] masked;

    assign dword = word_of(dest_i, dest_is_acc_i);
    assign shamt = src2_i[SHAMT_W-1:0];
    assign barrel_left = src1_i << shamt;
    assign barrel_arith_right = WORD_W'($signed(src1_i) >>> shamt);
    assign barrel_logic_right = src1_i >> shamt;
    assign masked = src1_i & imm_i;

    always_comb begin
        res_next = ACC_ZERO;
        res_we_next = 1'b0;
        carry_next = 1'b0;
        carry_we_next = 1'b0;
        ptr_next = WORD_ZERO;
        ptr_we_next = 1'b0;
        zero_next = 1'b0;
        neg_next = 1'b0;
        flags_we_next = 1'b0;
        addr_next = WORD_ZERO;
        addr_we_next = 1'b0;
        if (op_valid_i) begin
            unique case (op_code_i)
                OP_NONE: begin
                end
                OP_ARITH_SHIFT_LEFT_ONE: begin
                    res_we_next = 1'b1;
                    carry_we_next = 1'b1;
                    if (dest_is_acc_i) begin
                        res_next = {dest_i[ACC_W-2:0], 1'b0};
                        carry_next = dest_i[ACC_W-1];
                    end else begin
                        res_next = {20'h00000, dest_i[WORD_W-2:0], 1'b0};
                        carry_next = dest_i[WORD_W-1];
                    end
                end
                OP_ARITH_SHIFT_RIGHT_ONE: begin
                    res_we_next = 1'b1;
                    carry_we_next = 1'b1;
                    carry_next = dest_i[0];
                    if (dest_is_acc_i) begin
                        res_next = {dest_i[ACC_W-1], dest_i[ACC_W-1:1]};
                    end else begin
                        res_next = {20'h00000, dest_i[WORD_W-1], dest_i[WORD_W-1:1]};
                    end
                end
                OP_ARITH_BARREL_LEFT: begin
                    res_we_next = 1'b1;
                    res_next = place_signed(barrel_left, dest_is_acc_i);
                end
                OP_ARITH_BARREL_RIGHT: begin
                    res_we_next = 1'b1;
                    res_next = place_signed(barrel_arith_right, dest_is_acc_i);
                end
                OP_ARITH_SHIFT_ACCUMULATE: begin
                    res_we_next = 1'b1;
                    res_next = acc_i + acc_form(barrel_arith_right);
                end
                OP_LOGICAL_LEFT_ONE: begin
                    res_we_next = 1'b1;
                    carry_we_next = 1'b1;
                    carry_next = dword[WORD_W-1];
                    res_next = put_word(dest_i, {dword[WORD_W-2:0], 1'b0}, dest_is_acc_i);
                end
                OP_LOGICAL_RIGHT_ONE: begin
                    res_we_next = 1'b1;
                    carry_we_next = 1'b1;
                    carry_next = dword[0];
                    res_next = put_word(dest_i, {1'b0, dword[WORD_W-1:1]}, dest_is_acc_i);
                end
                OP_LOGICAL_BARREL_RIGHT: begin
                    res_we_next = 1'b1;
                    // Extension and low word are both cleared in an accumulator.
                    if (dest_is_acc_i) begin
                        res_next = {{EXT_W{1'b0}}, barrel_logic_right, WORD_ZERO};
                    end else begin
                        res_next = {20'h00000, barrel_logic_right};
                    end
                end
                OP_LOGICAL_SHIFT_ACCUMULATE: begin
                    res_we_next = 1'b1;
                    // A logical result is unsigned, so it joins the sum zero-extended.
                    res_next = acc_i + {{EXT_W{1'b0}}, barrel_logic_right, WORD_ZERO};
                end
                OP_ROTATE_LEFT_VIA_CARRY: begin
                    res_we_next = 1'b1;
                    carry_we_next = 1'b1;
                    carry_next = dword[WORD_W-1];
                    res_next = put_word(dest_i, {dword[WORD_W-2:0], carry_i}, dest_is_acc_i);
                end
                OP_ROTATE_RIGHT_VIA_CARRY: begin
                    res_we_next = 1'b1;
                    carry_we_next = 1'b1;
                    carry_next = dword[0];
                    res_next = put_word(dest_i, {carry_i, dword[WORD_W-1:1]}, dest_is_acc_i);
                end
                OP_PTR_INCREMENT: begin
                    ptr_we_next = 1'b1;
                    ptr_next = pointer_reg_i + WORD_ONE;
                end
                OP_PTR_DECREMENT: begin
                    ptr_we_next = 1'b1;
                    ptr_next = pointer_reg_i - WORD_ONE;
                end
                OP_PTR_ADD_OFFSET: begin
                    ptr_we_next = 1'b1;
                    ptr_next = pointer_reg_i + offset_i;
                end
                OP_PTR_TWO_ADD_SHORT: begin
                    ptr_we_next = 1'b1;
                    ptr_next = pointer_reg_i + {10'h000, short_addr_i};
                end
                OP_STACK_SUB_SHORT: begin
                    ptr_we_next = 1'b1;
                    ptr_next = pointer_reg_i - {10'h000, short_addr_i};
                end
                OP_PTR_ADD_LONG: begin
                    ptr_we_next = 1'b1;
                    ptr_next = pointer_reg_i + imm_i;
                end
                OP_TEST_THEN_DECREMENT: begin
                    // Flags describe the value before the decrement.
                    flags_we_next = 1'b1;
                    zero_next = (pointer_reg_i == WORD_ZERO);
                    neg_next = pointer_reg_i[WORD_W-1];
                    ptr_we_next = 1'b1;
                    ptr_next = pointer_reg_i - WORD_ONE;
                end
                OP_MASK_ALL_ONES_TEST: begin
                    // The operand source is trusted never to be the hardware stack register.
                    carry_we_next = 1'b1;
                    carry_next = (masked == imm_i);
                end
                OP_MASK_ALL_ZEROS_TEST: begin
                    carry_we_next = 1'b1;
                    carry_next = (masked == WORD_ZERO);
                end
                OP_SHORT_DIRECT_ADDRESS: begin
                    addr_we_next = 1'b1;
                    addr_next = {10'h000, short_addr_i};
                end
                OP_SHORT_IO_ADDRESS: begin
                    addr_we_next = 1'b1;
                    addr_next = IO_REGION_BASE | {10'h000, short_addr_i};
                end
                OP_AND_WITH_CONSTANT: begin
                    res_we_next = 1'b1;
                    res_next = put_word(dest_i, src1_i & imm_i, dest_is_acc_i);
                end
                OP_XOR_WITH_CONSTANT: begin
                    res_we_next = 1'b1;
                    res_next = put_word(dest_i, src1_i ^ imm_i, dest_is_acc_i);
                end
                OP_OR_WITH_CONSTANT: begin
                    res_we_next = 1'b1;
                    res_next = put_word(dest_i, src1_i | imm_i, dest_is_acc_i);
                end
                OP_INVERT_ALIAS: begin
                    res_we_next = 1'b1;
                    res_next = put_word(dest_i, ~src1_i, dest_is_acc_i);
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Result registers
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            result_o <= ACC_ZERO;
            result_we_o <= 1'b0;
        end else begin
            result_o <= res_next;
            result_we_o <= res_we_next;
        end
    end

    // The carry strobe rises for mask tests too, while the result strobe stays low.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            carry_o <= 1'b0;
            carry_we_o <= 1'b0;
        end else begin
            carry_o <= carry_next;
            carry_we_o <= carry_we_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pointer_reg_o <= WORD_ZERO;
            pointer_we_o <= 1'b0;
            ptr_zero_o <= 1'b0;
            ptr_negative_o <= 1'b0;
            ptr_flags_we_o <= 1'b0;
        end else begin
            pointer_reg_o <= ptr_next;
            pointer_we_o <= ptr_we_next;
            ptr_zero_o <= zero_next;
            ptr_negative_o <= neg_next;
            ptr_flags_we_o <= flags_we_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mem_addr_o <= WORD_ZERO;
            mem_addr_valid_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            mem_addr_o <= addr_next;
            mem_addr_valid_o <= addr_we_next;
            done_o <= op_valid_i;
        end
    end

endmodule

// >>> tb/core_regfile_model.sv
// Model of the core register file that holds the carry flag for the datapath.
// Assumes one clock and a synchronous active-high reset shared with the datapath.
`timescale 1ns/100ps
module core_regfile_model (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic carry_we_i,
    input wire logic carry_new_i,
    output logic carry_o
);
    // Mask-test operands are never the hardware stack register.
    // Carry is written at the edge that samples the strobe.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            carry_o <= 1'b0;
        end else if (carry_we_i) begin
            carry_o <= carry_new_i;
        end
    end
endmodule

// >>> tb/shift_pointer_bittest_datapath_assertions.sv
// Concurrent checks on the ports of the shift, pointer and mask-test datapath.
// Assumes it is bound to the datapath and sees its ports only.
`timescale 1ns/100ps
module dp_rule_checker
    import shift_ptr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire op_t op_code_i,
    input wire logic [WORD_W-1:0] src1_i,
    input wire logic [WORD_W-1:0] imm_i,
    input wire logic [WORD_W-1:0] offset_i,
    input wire logic [WORD_W-1:0] pointer_reg_i,
    input wire logic [SHORT_ADDR_W-1:0] short_addr_i,
    input wire logic result_we_o,
    input wire logic carry_o,
    input wire logic carry_we_o,
    input wire logic [WORD_W-1:0] pointer_reg_o,
    input wire logic pointer_we_o,
    input wire logic ptr_zero_o,
    input wire logic ptr_flags_we_o,
    input wire logic [WORD_W-1:0] mem_addr_o,
    input wire logic mem_addr_valid_o
);
    logic ones_hit_reg;
    logic zeros_hit_reg;
    always_ff @(posedge clock_i) begin
        ones_hit_reg <= (src1_i & imm_i) == imm_i;
        zeros_hit_reg <= (src1_i & imm_i) == WORD_ZERO;
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_ones;
        op_valid_i && op_code_i == OP_MASK_ALL_ONES_TEST |=> carry_we_o && carry_o == ones_hit_reg;
    endproperty
    a_ones: assert property (p_ones) else $error("all-ones test carry wrong");
    property p_zeros;
        op_valid_i && op_code_i == OP_MASK_ALL_ZEROS_TEST |-> ##1 carry_we_o && carry_o == zeros_hit_reg;
    endproperty
    a_zeros: assert property (p_zeros) else $error("all-zeros test carry wrong");
    property p_keep;
        op_valid_i && op_code_i inside {OP_MASK_ALL_ONES_TEST, OP_MASK_ALL_ZEROS_TEST}
            |=> !result_we_o && !pointer_we_o;
    endproperty
    a_keep: assert property (p_keep) else $error("mask test wrote a result");
    property p_inc;
        op_valid_i && op_code_i == OP_PTR_INCREMENT |=> pointer_we_o && pointer_reg_o == $past(pointer_reg_i) + WORD_ONE;
    endproperty
    a_inc: assert property (p_inc) else $error("pointer increment wrong");
    property p_offset;
        op_valid_i && op_code_i == OP_PTR_ADD_OFFSET |=> pointer_reg_o == $past(pointer_reg_i) + $past(offset_i);
    endproperty
    a_offset: assert property (p_offset) else $error("indexed pointer update wrong");
    property p_stack;
        op_valid_i && op_code_i == OP_STACK_SUB_SHORT
            |=> pointer_reg_o == $past(pointer_reg_i) - {10'h000, $past(short_addr_i)};
    endproperty
    a_stack: assert property (p_stack) else $error("stack adjustment wrong");
    property p_ttd;
        op_valid_i && op_code_i == OP_TEST_THEN_DECREMENT |=> ptr_flags_we_o
            && ptr_zero_o == ($past(pointer_reg_i) == WORD_ZERO) && pointer_reg_o == $past(pointer_reg_i) - WORD_ONE;
    endproperty
    a_ttd: assert property (p_ttd) else $error("test then decrement wrong");
    property p_io;
        op_valid_i && op_code_i == OP_SHORT_IO_ADDRESS
            |=> mem_addr_valid_o && mem_addr_o == (IO_REGION_BASE | {10'h000, $past(short_addr_i)});
    endproperty
    a_io: assert property (p_io) else $error("short io address wrong");
    property p_direct;
        op_valid_i && op_code_i == OP_SHORT_DIRECT_ADDRESS |=> mem_addr_o == {10'h000, $past(short_addr_i)};
    endproperty
    a_direct: assert property (p_direct) else $error("short direct address wrong");
endmodule
bind shift_pointer_bittest_datapath dp_rule_checker chk (.clock_i, .rst_i, .op_valid_i, .op_code_i,
    .src1_i, .imm_i, .offset_i, .pointer_reg_i, .short_addr_i, .result_we_o, .carry_o, .carry_we_o,
    .pointer_reg_o, .pointer_we_o, .ptr_zero_o, .ptr_flags_we_o, .mem_addr_o, .mem_addr_valid_o);

// >>> tb/shift_pointer_bittest_datapath_test.sv
// Self-checking bench for the shift, pointer and mask-test datapath.
// Assumes the package, datapath, carry model and checker are compiled first.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module shift_pointer_bittest_datapath_test;
    import shift_ptr_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic op_valid_i = 1'b0, dest_is_acc_i = 1'b0, carry_i;
    op_t op_code_i = OP_NONE;
    op_t n_op;
    logic [ACC_W-1:0] dest_i = '0, acc_i = '0, result_o, n_dest, n_acc, e_res;
    logic [WORD_W-1:0] src1_i = '0, src2_i = '0, pointer_reg_i = '0, offset_i = '0, imm_i = '0;
    logic [WORD_W-1:0] pointer_reg_o, mem_addr_o, n_s1, n_s2, n_p, n_off, n_im, e_ptr, e_addr;
    logic [WORD_W-1:0] w, nw, bw, lw;
    logic [SHORT_ADDR_W-1:0] short_addr_i = '0, n_sa;
    logic result_we_o, carry_o, carry_we_o, pointer_we_o, ptr_zero_o, ptr_negative_o;
    logic ptr_flags_we_o, mem_addr_valid_o, done_o, n_acc_d;
    logic e_done, e_rwe, e_cwe, e_c, e_pwe, e_fwe, e_z, e_n, e_awe, wop;
    logic [31:0] seed = 32'h7;
    int n_fail = 0, num_checks = 0, cycles = 0;

    core_regfile_model partner (.clock_i(clock_i), .rst_i(rst_i), .carry_we_i(carry_we_o),
        .carry_new_i(carry_o), .carry_o(carry_i));
    shift_pointer_bittest_datapath dut (.*);

    always #5 clock_i = ~clock_i;

    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Accumulator form is an extension, the word and sixteen zero low bits.
    function automatic logic [ACC_W-1:0] wide(input logic [WORD_W-1:0] x, input logic sx);
        return n_acc_d ? {sx ? {4{x[15]}} : 4'h0, x, 16'h0000} : {20'h00000, x};
    endfunction

    task automatic rnd();
        n_op = op_t'(5'(next_rand() % 27));
        n_acc_d = 1'(next_rand());
        n_dest = 36'({next_rand(), next_rand()});
        n_acc = 36'({next_rand(), next_rand()});
        {n_s1, n_s2} = next_rand();
        {n_p, n_off} = next_rand();
        {n_im, n_sa} = 22'(next_rand());
    endtask

    task automatic calc(input logic v);
        w = n_acc_d ? n_dest[31:16] : n_dest[15:0];
        bw = $signed(n_s1) >>> n_s2[3:0];
        lw = n_s1 >> n_s2[3:0];
        {e_rwe, e_cwe, e_c, e_pwe, e_fwe, e_awe, e_z, e_n, wop} = '0;
        {e_res, e_ptr, e_addr, e_done} = {68'h0, v};
        if (v) case (n_op)
            OP_ARITH_SHIFT_LEFT_ONE: {e_rwe, e_cwe, e_c, e_res} = {2'b11, n_dest[n_acc_d ? 35 : 15], n_dest << 1};
            OP_ARITH_SHIFT_RIGHT_ONE: {e_rwe, e_cwe, e_c, e_res} = {2'b11, n_dest[0],
                n_acc_d ? {n_dest[35], n_dest[35:1]} : {20'h00000, n_dest[15], n_dest[15:1]}};
            OP_ARITH_BARREL_LEFT: {e_rwe, e_res} = {1'b1, wide(n_s1 << n_s2[3:0], 1'b1)};
            OP_ARITH_BARREL_RIGHT: {e_rwe, e_res} = {1'b1, wide(bw, 1'b1)};
            OP_LOGICAL_BARREL_RIGHT: {e_rwe, e_res} = {1'b1, wide(lw, 1'b0)};
            OP_ARITH_SHIFT_ACCUMULATE: {e_rwe, e_res} = {1'b1, n_acc + wide(bw, 1'b1)};
            OP_LOGICAL_SHIFT_ACCUMULATE: {e_rwe, e_res} = {1'b1, n_acc + wide(lw, 1'b0)};
            OP_LOGICAL_LEFT_ONE: {wop, e_rwe, e_cwe, e_c, nw} = {3'b111, w[15], w[14:0], 1'b0};
            OP_LOGICAL_RIGHT_ONE: {wop, e_rwe, e_cwe, e_c, nw} = {3'b111, w[0], 1'b0, w[15:1]};
            OP_ROTATE_LEFT_VIA_CARRY: {wop, e_rwe, e_cwe, e_c, nw} = {3'b111, w[15], w[14:0], carry_i};
            OP_ROTATE_RIGHT_VIA_CARRY: {wop, e_rwe, e_cwe, e_c, nw} = {3'b111, w[0], carry_i, w[15:1]};
            OP_AND_WITH_CONSTANT: {wop, e_rwe, nw} = {2'b11, n_s1 & n_im};
            OP_XOR_WITH_CONSTANT: {wop, e_rwe, nw} = {2'b11, n_s1 ^ n_im};
            OP_OR_WITH_CONSTANT: {wop, e_rwe, nw} = {2'b11, n_s1 | n_im};
            OP_INVERT_ALIAS: {wop, e_rwe, nw} = {2'b11, ~n_s1};
            OP_PTR_INCREMENT: {e_pwe, e_ptr} = {1'b1, n_p + 16'h0001};
            OP_PTR_DECREMENT: {e_pwe, e_ptr} = {1'b1, n_p - 16'h0001};
            OP_PTR_ADD_OFFSET: {e_pwe, e_ptr} = {1'b1, n_p + n_off};
            OP_PTR_TWO_ADD_SHORT: {e_pwe, e_ptr} = {1'b1, n_p + {10'h000, n_sa}};
            OP_STACK_SUB_SHORT: {e_pwe, e_ptr} = {1'b1, n_p - {10'h000, n_sa}};
            OP_PTR_ADD_LONG: {e_pwe, e_ptr} = {1'b1, n_p + n_im};
            OP_TEST_THEN_DECREMENT: {e_pwe, e_fwe, e_z, e_n, e_ptr} = {2'b11, n_p == 16'h0000, n_p[15], n_p - 16'h0001};
            OP_MASK_ALL_ONES_TEST: {e_cwe, e_c} = {1'b1, (n_s1 & n_im) == n_im};
            OP_MASK_ALL_ZEROS_TEST: {e_cwe, e_c} = {1'b1, (n_s1 & n_im) == 16'h0000};
            OP_SHORT_DIRECT_ADDRESS: {e_awe, e_addr} = {1'b1, 10'h000, n_sa};
            OP_SHORT_IO_ADDRESS: {e_awe, e_addr} = {1'b1, IO_REGION_BASE | {10'h000, n_sa}};
            default: ;
        endcase
        if (wop) e_res = n_acc_d ? {n_dest[35:32], nw, n_dest[15:0]} : {20'h00000, nw};
        if (!n_acc_d) e_res[35:16] = 20'h00000;
    endtask

    task automatic check();
        `CHK("done_o", e_done, done_o)
        `CHK("result_we_o", e_rwe, result_we_o)
        if (e_rwe) `CHK("result_o", e_res, result_o)
        `CHK("carry_we_o", e_cwe, carry_we_o)
        if (e_cwe) `CHK("carry_o", e_c, carry_o)
        `CHK("pointer_we_o", e_pwe, pointer_we_o)
        if (e_pwe) `CHK("pointer_reg_o", e_ptr, pointer_reg_o)
        `CHK("ptr_flags_we_o", e_fwe, ptr_flags_we_o)
        if (e_fwe) `CHK("ptr flags", {e_z, e_n}, {ptr_zero_o, ptr_negative_o})
        `CHK("mem_addr_valid_o", e_awe, mem_addr_valid_o)
        if (e_awe) `CHK("mem_addr_o", e_addr, mem_addr_o)
    endtask

    // Each step drives one request and checks the answer to the one before it.
    task automatic step(input logic v);
        @(posedge clock_i);
        if (n_op inside {OP_ARITH_SHIFT_ACCUMULATE, OP_LOGICAL_SHIFT_ACCUMULATE}) n_acc_d = 1'b1;
        op_valid_i <= v;
        op_code_i <= n_op;
        dest_is_acc_i <= n_acc_d;
        dest_i <= n_dest;
        acc_i <= n_acc;
        {src1_i, src2_i, pointer_reg_i} <= {n_s1, n_s2, n_p};
        {offset_i, imm_i, short_addr_i} <= {n_off, n_im, n_sa};
        #1;
        check();
        calc(v);
    endtask

    // The mask doubles as the barrel shift amount.
    task automatic corner(input op_t op, input logic [15:0] s1, im, p, input logic [5:0] sa);
        rnd();
        {n_op, n_s1, n_im, n_s2, n_p, n_sa} = {op, s1, im, im, p, sa};
        step(1'b1);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        rnd();
        calc(1'b0);
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        step(1'b0);
        corner(OP_MASK_ALL_ONES_TEST, 16'h00F3, 16'h0003, 16'h0000, 6'h00);
        corner(OP_MASK_ALL_ONES_TEST, 16'h00F3, 16'h0007, 16'h0000, 6'h00);
        corner(OP_MASK_ALL_ONES_TEST, 16'h0000, 16'h0000, 16'h0000, 6'h00);
        corner(OP_MASK_ALL_ZEROS_TEST, 16'h00F3, 16'h0F00, 16'h0000, 6'h00);
        corner(OP_MASK_ALL_ZEROS_TEST, 16'h00F3, 16'h0001, 16'h0000, 6'h00);
        corner(OP_TEST_THEN_DECREMENT, 16'h0000, 16'h0000, 16'h0000, 6'h00);
        corner(OP_TEST_THEN_DECREMENT, 16'h0000, 16'h0000, 16'h8000, 6'h00);
        corner(OP_SHORT_IO_ADDRESS, 16'h0000, 16'h0000, 16'h0000, 6'h3F);
        corner(OP_SHORT_DIRECT_ADDRESS, 16'h0000, 16'h0000, 16'h0000, 6'h3F);
        corner(OP_STACK_SUB_SHORT, 16'h0000, 16'h0000, 16'h0000, 6'h3F);
        corner(OP_PTR_TWO_ADD_SHORT, 16'h0000, 16'h0000, 16'hFFFF, 6'h01);
        corner(OP_PTR_ADD_LONG, 16'h0000, 16'hFFF0, 16'h0010, 6'h00);
        corner(OP_ARITH_BARREL_RIGHT, 16'h8001, 16'h000F, 16'h0000, 6'h00);
        corner(OP_LOGICAL_BARREL_RIGHT, 16'h8001, 16'h000F, 16'h0000, 6'h00);
        corner(OP_ROTATE_LEFT_VIA_CARRY, 16'h0000, 16'h0000, 16'h0000, 6'h00);
        corner(OP_ROTATE_RIGHT_VIA_CARRY, 16'h0000, 16'h0000, 16'h0000, 6'h00);
        for (int i = 0; i < 27; i++) begin
            rnd();
            n_op = op_t'(5'(i));
            step(1'b1);
        end
        repeat (400) begin
            rnd();
            step(next_rand() % 4 != 0);
        end
        step(1'b0);
        step(1'b0);
        print_verdict();
    end
endmodule
